// File: lfs_pkg.sv
// Constants, carrier types and the contract list of the fault and startup sequencer.
// Contract
// RULE1: Protection pin above overvoltage threshold for 40 us declares fault, stops switching.
// RULE2: Protection pin below temperature threshold means over-temperature and enters fault.
// RULE3: After over-temperature fault wait 1 s, then restart or stay idle per comparator.
// RULE4: Temperature check is off in burst mode, back on when normal switching resumes.
// RULE5: Zero-current event during a gate pulse ends that pulse at once.
// RULE6: Separate high-side and low-side zero-current comparators; the inactive one is ignored.
// RULE7: Zero-current comparators are blanked after each rising gate edge for blanking time.
// RULE8: Each zero-current event requests a slow step down of the soft-start ramp.
// RULE9: Zero-current events lasting past a configurable timeout stop switching with a fault.
// RULE10: Overcurrent ends high pulse above positive limit, low pulse below negative limit.
// RULE11: Seven consecutive cycles with overcurrent termination enter the fault state.
// RULE12: Control above overload threshold limits power and runs a timer; expiry faults.
// RULE13: Supply overvoltage enters fault at once and retries after 1 s idle.
// RULE14: First start charges with low current below short threshold, else high current.
// RULE15: Once the 5 V rail is up, light-load and timing-set pins are programmed first.
// RULE16: With high-voltage startup on, timing-set pin is driven high until supply is full.
// RULE17: Above self-start threshold charging stops, converter starts, timing-set pin goes low.
// RULE18: Supply below restart threshold while programming or holding recharges with high current.
// RULE19: After startup, charging stays off until supply drops under switch restart threshold.
// RULE20: In running state supply below stop-switching threshold faults and restarts normally.
// RULE21: Fault retry waits 1 s, timing-set high while supply is above falling UVLO.
// RULE22: Restart with supply above self-start threshold skips the charging phase.
// RULE23: Input sense back above brown-in starts soft start without the fault idle wait.
// RULE24: Comparator inputs are synchronized; fault forces both gate outputs low.
// RULE25: One state machine arbitrates all faults; earliest detected fault takes effect.
package lfs_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned OVP_TIME_US = 40;
    localparam int unsigned OVP_CYCLES = OVP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned IDLE_TIME_MS = 1000;
    localparam int unsigned IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned OCP_LIMIT = 7;
    localparam int unsigned LEB_CYCLES_DEF = 4;
    localparam int unsigned OLP_CYCLES_DEF = 1_000_000;
    localparam int unsigned ZCS_CYCLES_DEF = 20_000;
    localparam int unsigned PRGM_CYCLES_DEF = 200;

    typedef enum logic [2:0] {
        LFS_IDLE = 3'b000,
        LFS_PRGM = 3'b001,
        LFS_START = 3'b010,
        LFS_RUN = 3'b011,
        LFS_FAULT = 3'b100
    } lfs_state_t;

    typedef enum logic [2:0] {
        LFS_F_NONE = 3'h0,
        LFS_F_OVP = 3'h1,
        LFS_F_OTP = 3'h2,
        LFS_F_ZCS = 3'h3,
        LFS_F_OCP = 3'h4,
        LFS_F_OLP = 3'h5,
        LFS_F_VCC = 3'h6,
        LFS_F_UV = 3'h7
    } lfs_fault_t;

    // Raw comparator flags from the analog front end.
    typedef struct packed {
        logic prot_above_ovp;
        logic prot_below_otp;
        logic zcs_high;
        logic zcs_low;
        logic ocp_pos;
        logic ocp_neg;
        logic control_above_olp;
        logic supply_ovp;
        logic supply_above_short;
        logic supply_above_uvlo_r;
        logic supply_above_self_start;
        logic supply_above_restart;
        logic supply_above_switch_restart;
        logic supply_above_stop_switching;
        logic supply_above_uvlo_f;
        logic input_sense_brown_in;
        logic rail_good;
    } lfs_cmp_t;

    // Charge, pin, power-limit and ramp step-down control outputs.
    typedef struct packed {
        logic charge_low;
        logic charge_high;
        logic timing_set_high;
        logic program_pins;
        logic power_limit;
        logic ramp_step_down;
    } lfs_ctl_t;
endpackage

// File: lfs_sequencer.sv
// Fault detection, gate termination and startup sequencing of the controller.
`timescale 1ns/1ps
module lfs_sequencer import lfs_pkg::*; #(
    parameter int unsigned LEB_CYCLES = LEB_CYCLES_DEF,
    parameter int unsigned OLP_CYCLES = OLP_CYCLES_DEF,
    parameter int unsigned ZCS_CYCLES = ZCS_CYCLES_DEF,
    parameter int unsigned PRGM_CYCLES = PRGM_CYCLES_DEF,
    parameter int unsigned OVP_DELAY = OVP_CYCLES,
    parameter int unsigned IDLE_DELAY = IDLE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire lfs_cmp_t cmp_raw,
    input wire logic hv_startup_enable,
    input wire logic burst_mode,
    input wire logic high_side_req,
    input wire logic low_side_req,
    output logic high_side_gate,
    output logic low_side_gate,
    output lfs_ctl_t ctl,
    output lfs_state_t state,
    output lfs_fault_t fault_cause
);
    if (LEB_CYCLES < 1 || OLP_CYCLES < 2 || ZCS_CYCLES < 2
        || PRGM_CYCLES < 1 || OVP_DELAY < 2 || IDLE_DELAY < 2) begin : g_bad
        $error("lfs_sequencer: counts too small");
    end

    localparam int CW = 32;

    // Two-stage synchroniser; only stage two is read by logic.
    lfs_cmp_t sync1, cmp;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= '0;
            cmp <= '0;
        end else begin
            sync1 <= cmp_raw; // see RULE24
            cmp <= sync1;
        end
    end

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v,
                                              input logic [CW-1:0] lim);
        sat_inc = (v >= lim) ? lim : v + 32'h1;
    endfunction

    // Gate and per-cycle state.
    logic hs_on, ls_on, next_hs_on, next_ls_on;
    logic hs_cut, ls_cut, next_hs_cut, next_ls_cut;
    logic [CW-1:0] leb_cnt, next_leb_cnt;
    logic [2:0] ocp_cnt, next_ocp_cnt;
    logic cyc_ocp, next_cyc_ocp;
    logic [CW-1:0] ovp_cnt, next_ovp_cnt;
    logic [CW-1:0] olp_cnt, next_olp_cnt;
    logic [CW-1:0] zcs_cnt, next_zcs_cnt;
    logic [CW-1:0] tmr, next_tmr;
    logic burst_d, next_burst_d;
    logic otp_en, next_otp_en;
    logic charge_armed, next_charge_armed;
    logic brown_out, next_brown_out;
    logic ramp_q;
    lfs_state_t next_state;
    lfs_fault_t next_fault_cause;
    logic zcs_hit, ocp_hit, running, next_ramp_step;
    lfs_fault_t det;

    assign running = (state == LFS_RUN) || (state == LFS_START);
    // Only the comparator of the active gate counts, after blanking.
    assign zcs_hit = (leb_cnt == '0)
        && ((hs_on && cmp.zcs_high) || (ls_on && cmp.zcs_low)); // see RULE6
    assign ocp_hit = (hs_on && cmp.ocp_pos) || (ls_on && cmp.ocp_neg);

    always_comb begin
        next_hs_on = 1'b0;
        next_ls_on = 1'b0;
        next_hs_cut = hs_cut;
        next_ls_cut = ls_cut;
        next_leb_cnt = (leb_cnt != '0) ? leb_cnt - 32'h1 : '0;
        next_ocp_cnt = ocp_cnt;
        next_cyc_ocp = cyc_ocp;
        next_ramp_step = 1'b0;
        // Gates drop on the edge that enters the fault state, not one later.
        if (running && det == LFS_F_NONE) begin
            if (!high_side_req) next_hs_cut = 1'b0;
            if (!low_side_req) next_ls_cut = 1'b0;
            if (high_side_req && !hs_cut && !(zcs_hit || ocp_hit && hs_on))
                next_hs_on = 1'b1;
            if (low_side_req && !ls_cut && !high_side_req
                && !(zcs_hit || ocp_hit && ls_on))
                next_ls_on = 1'b1;
            if (hs_on && (zcs_hit || ocp_hit)) next_hs_cut = 1'b1; // see RULE5
            if (ls_on && (zcs_hit || ocp_hit)) next_ls_cut = 1'b1; // see RULE10
            if ((next_hs_on && !hs_on) || (next_ls_on && !ls_on))
                next_leb_cnt = CW'(LEB_CYCLES); // see RULE7
            if (zcs_hit) next_ramp_step = 1'b1; // see RULE8
            if (ocp_hit) next_cyc_ocp = 1'b1;
            // A switching cycle closes at each new high-side pulse.
            if (next_hs_on && !hs_on) begin
                next_cyc_ocp = 1'b0;
                next_ocp_cnt = cyc_ocp ? ocp_cnt + 3'h1 : 3'h0; // see RULE11
            end
        end else begin
            next_hs_cut = 1'b0;
            next_ls_cut = 1'b0;
            next_ocp_cnt = 3'h0;
            next_cyc_ocp = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            hs_cut <= 1'b0;
            ls_cut <= 1'b0;
            leb_cnt <= '0;
            ocp_cnt <= 3'h0;
            cyc_ocp <= 1'b0;
            ramp_q <= 1'b0;
        end else begin
            hs_on <= next_hs_on;
            ls_on <= next_ls_on;
            hs_cut <= next_hs_cut;
            ls_cut <= next_ls_cut;
            leb_cnt <= next_leb_cnt;
            ocp_cnt <= next_ocp_cnt;
            cyc_ocp <= next_cyc_ocp;
            ramp_q <= next_ramp_step;
        end
    end
    assign high_side_gate = hs_on;
    assign low_side_gate = ls_on;

    // Fault timers and detection, fixed priority among same-cycle faults.
    always_comb begin
        next_ovp_cnt = cmp.prot_above_ovp ? sat_inc(ovp_cnt, CW'(OVP_DELAY))
                                          : '0; // see RULE1
        next_olp_cnt = (running && cmp.control_above_olp)
            ? sat_inc(olp_cnt, CW'(OLP_CYCLES)) : '0; // see RULE12
        // A pulse that outlives blanking without a hit ends the streak.
        if (!running || ((hs_on || ls_on) && leb_cnt == '0 && !zcs_hit))
            next_zcs_cnt = '0;
        else if (zcs_hit || zcs_cnt != '0)
            next_zcs_cnt = sat_inc(zcs_cnt, CW'(ZCS_CYCLES)); // see RULE9
        else
            next_zcs_cnt = '0;
        next_burst_d = burst_mode;
        next_otp_en = otp_en;
        if (burst_mode) next_otp_en = 1'b0; // see RULE4
        else if (burst_d) next_otp_en = 1'b1;
        det = LFS_F_NONE;
        if (cmp.supply_ovp) det = LFS_F_VCC; // see RULE13
        else if (ovp_cnt >= CW'(OVP_DELAY)) det = LFS_F_OVP;
        else if (otp_en && cmp.prot_below_otp) det = LFS_F_OTP; // see RULE2
        else if (running && ocp_cnt >= 3'(OCP_LIMIT)) det = LFS_F_OCP;
        else if (olp_cnt >= CW'(OLP_CYCLES)) det = LFS_F_OLP;
        else if (zcs_cnt >= CW'(ZCS_CYCLES)) det = LFS_F_ZCS;
        else if ((running && !cmp.input_sense_brown_in)
                 || (state == LFS_RUN && !cmp.supply_above_stop_switching))
            det = LFS_F_UV; // see RULE20
    end

    // Main sequencer.
    always_comb begin
        next_state = state;
        next_fault_cause = fault_cause;
        next_tmr = (tmr != '0) ? tmr - 32'h1 : '0;
        next_charge_armed = charge_armed;
        next_brown_out = brown_out;
        case (state)
            LFS_IDLE: begin
                if (cmp.rail_good && cmp.input_sense_brown_in) begin
                    next_state = LFS_PRGM; // see RULE15
                    next_tmr = CW'(PRGM_CYCLES);
                end
            end
            LFS_PRGM: begin
                if (tmr == '0 && cmp.supply_above_self_start) begin
                    next_state = LFS_START; // see RULE17
                    next_charge_armed = 1'b0;
                end
            end
            LFS_START: begin
                if (cmp.supply_above_stop_switching) next_state = LFS_RUN;
            end
            LFS_RUN: begin
                if (!cmp.supply_above_switch_restart)
                    next_charge_armed = 1'b1; // see RULE19
            end
            LFS_FAULT: begin
                if (brown_out && cmp.input_sense_brown_in
                    && cmp.rail_good) begin
                    next_state = LFS_PRGM; // see RULE23
                    next_tmr = CW'(PRGM_CYCLES);
                    next_fault_cause = LFS_F_NONE;
                    next_brown_out = 1'b0;
                end else if (tmr == '0) begin
                    if (fault_cause != LFS_F_OTP || cmp.prot_above_ovp
                        || !cmp.prot_below_otp) begin
                        next_state = LFS_IDLE; // see RULE3
                        next_fault_cause = LFS_F_NONE;
                        next_brown_out = 1'b0;
                        next_charge_armed = 1'b1;
                    end
                end
            end
            default: next_state = LFS_IDLE;
        endcase
        if (state != LFS_FAULT && state != LFS_IDLE && det != LFS_F_NONE) begin
            next_state = LFS_FAULT; // see RULE25
            next_fault_cause = det;
            next_tmr = CW'(IDLE_DELAY); // see RULE21
            // Only a brown-out skips the idle wait; a supply dip does not.
            next_brown_out = (det == LFS_F_UV) && !cmp.input_sense_brown_in;
            next_charge_armed = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= LFS_IDLE;
            fault_cause <= LFS_F_NONE;
            tmr <= '0;
            charge_armed <= 1'b1;
            ovp_cnt <= '0;
            olp_cnt <= '0;
            zcs_cnt <= '0;
            burst_d <= 1'b0;
            otp_en <= 1'b1;
            brown_out <= 1'b0;
        end else begin
            state <= next_state;
            fault_cause <= next_fault_cause;
            tmr <= next_tmr;
            charge_armed <= next_charge_armed;
            ovp_cnt <= next_ovp_cnt;
            olp_cnt <= next_olp_cnt;
            zcs_cnt <= next_zcs_cnt;
            burst_d <= next_burst_d;
            otp_en <= next_otp_en;
            brown_out <= next_brown_out;
        end
    end

    // Charge current and pin roles. Above self-start the charger stays off,
    // which also skips charging on a warm restart.
    logic chg;
    always_comb begin
        chg = hv_startup_enable && charge_armed
            && !cmp.supply_above_self_start && state != LFS_FAULT; // see RULE22
        if ((state == LFS_PRGM) && !cmp.supply_above_restart)
            chg = hv_startup_enable; // see RULE18
        ctl.charge_low = chg && !cmp.supply_above_short
            && state == LFS_IDLE; // see RULE14
        ctl.charge_high = chg && !ctl.charge_low;
        ctl.program_pins = (state == LFS_PRGM);
        ctl.timing_set_high = hv_startup_enable
            && ((state == LFS_PRGM) || (state == LFS_IDLE && cmp.rail_good)
                || (state == LFS_FAULT && cmp.supply_above_uvlo_f)); // see RULE16
        ctl.power_limit = running && cmp.control_above_olp;
        ctl.ramp_step_down = ramp_q;
    end

    chk_fault_gates: assert property (@(posedge sys_clk) disable iff (rst)
        state == LFS_FAULT |-> !high_side_gate && !low_side_gate) // see RULE24
        else $error("gate active in fault");
    chk_ovp_delay: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ovp_cnt == CW'(OVP_DELAY)) && state == LFS_RUN
        |=> state == LFS_FAULT) // see RULE1
        else $error("ovp did not fault");
    chk_hs_zcs_cut: assert property (@(posedge sys_clk) disable iff (rst)
        hs_on && zcs_hit |=> !high_side_gate) // see RULE5
        else $error("high pulse not cut on zcs");
    chk_ocp_cut: assert property (@(posedge sys_clk) disable iff (rst)
        ls_on && cmp.ocp_neg |=> !low_side_gate) // see RULE10
        else $error("low pulse not cut on ocp");
    chk_leb_blank: assert property (@(posedge sys_clk) disable iff (rst)
        hs_on && leb_cnt != '0 && cmp.zcs_high && !cmp.ocp_pos
        && high_side_req && det == LFS_F_NONE |=> high_side_gate) // see RULE7
        else $error("zcs not blanked");
    chk_ocp_count: assert property (@(posedge sys_clk) disable iff (rst)
        running && ocp_cnt == 3'(OCP_LIMIT) && !cmp.supply_ovp
        |=> state == LFS_FAULT) // see RULE11
        else $error("ocp count did not fault");
    chk_vcc_ovp: assert property (@(posedge sys_clk) disable iff (rst)
        state == LFS_RUN && cmp.supply_ovp
        |=> state == LFS_FAULT && fault_cause == LFS_F_VCC) // see RULE13
        else $error("supply ovp missed");
    chk_start_charge: assert property (@(posedge sys_clk) disable iff (rst)
        state == LFS_START |-> !ctl.charge_low && !ctl.timing_set_high) // see RULE17
        else $error("charger or pin active after self start");
    chk_burst_otp: assert property (@(posedge sys_clk) disable iff (rst)
        burst_mode |=> !otp_en) // see RULE4
        else $error("otp active in burst");
    chk_zcs_timeout: assert property (@(posedge sys_clk) disable iff (rst)
        running && zcs_cnt >= CW'(ZCS_CYCLES)
        |=> state == LFS_FAULT) // see RULE9
        else $error("persistent zcs did not fault");
    chk_brown_restart: assert property (@(posedge sys_clk) disable iff (rst)
        state == LFS_FAULT && brown_out && cmp.input_sense_brown_in
        && cmp.rail_good |=> state == LFS_PRGM) // see RULE23
        else $error("brown in did not restart");
    chk_uv_stop: assert property (@(posedge sys_clk) disable iff (rst)
        state == LFS_RUN && !cmp.supply_above_stop_switching
        |=> state == LFS_FAULT) // see RULE20
        else $error("supply drop did not fault");
endmodule

// File: lfs_front_model.sv
// Behavioural model of the analog comparators and the external PFC stage.
`timescale 1ns/1ps
module lfs_front_model import lfs_pkg::*; #(
    parameter int SHORT_MV = 1000,
    parameter int UVLO_F_MV = 8000,
    parameter int STOP_MV = 8500,
    parameter int RESTART_MV = 9000,
    parameter int SW_RESTART_MV = 9500,
    parameter int UVLO_R_MV = 12000,
    parameter int SELF_MV = 15000,
    parameter int OVP_MV = 20000
) (
    input wire logic [31:0] supply_mv,
    input wire lfs_cmp_t flags,
    input wire lfs_ctl_t ctl,
    output lfs_cmp_t cmp_raw,
    output logic pfc_on
);
    lfs_cmp_t cmp_now;

    always_comb begin
        cmp_now = flags;
        cmp_now.supply_above_short = supply_mv > SHORT_MV;
        cmp_now.supply_above_uvlo_f = supply_mv > UVLO_F_MV;
        cmp_now.supply_above_stop_switching = supply_mv > STOP_MV;
        cmp_now.supply_above_restart = supply_mv > RESTART_MV;
        cmp_now.supply_above_switch_restart = supply_mv > SW_RESTART_MV;
        cmp_now.supply_above_uvlo_r = supply_mv > UVLO_R_MV;
        cmp_now.supply_above_self_start = supply_mv > SELF_MV;
        cmp_now.supply_ovp = supply_mv > OVP_MV;
    end

    // Comparators are not clock aligned, so edges land between clock edges.
    assign #3 cmp_raw = cmp_now;
    // The PFC stage runs only while the timing-set pin is low.
    assign pfc_on = ~ctl.timing_set_high;
endmodule

// File: lfs_sequencer_tb.sv
// Self-checking testbench of the fault and startup sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module lfs_sequencer_tb import lfs_pkg::*;;
    localparam int OVPD = 40;
    localparam int IDLED = 50;
    localparam int OLPC = 30;
    localparam int ZCSC = 30;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    lfs_cmp_t flags = '0;
    lfs_cmp_t cmp_raw;
    logic [31:0] supply_mv = 32'h0;
    logic hv_startup_enable = 1'b0;
    logic burst_mode = 1'b0;
    logic high_side_req = 1'b0;
    logic low_side_req = 1'b0;
    logic high_side_gate, low_side_gate, pfc_on;
    lfs_ctl_t ctl;
    lfs_state_t state;
    lfs_fault_t fault_cause;
    int errors = 0;
    int tests_run = 0;

    lfs_front_model lfs_front_model_inst (.supply_mv(supply_mv),
        .flags(flags), .ctl(ctl), .cmp_raw(cmp_raw), .pfc_on(pfc_on));
    lfs_sequencer #(.LEB_CYCLES(4), .OLP_CYCLES(OLPC), .ZCS_CYCLES(ZCSC),
        .PRGM_CYCLES(20), .OVP_DELAY(OVPD), .IDLE_DELAY(IDLED)
    ) lfs_sequencer_inst (.sys_clk(sys_clk), .rst(rst), .cmp_raw(cmp_raw),
        .hv_startup_enable(hv_startup_enable), .burst_mode(burst_mode),
        .high_side_req(high_side_req), .low_side_req(low_side_req),
        .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
        .ctl(ctl), .state(state), .fault_cause(fault_cause));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Waits for state s to be reached, or to be left when leave is set.
    task automatic wait_st(input lfs_state_t s, input int lim,
                           input bit leave, output int n);
        n = 0;
        while (((state === s) == leave) && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if ((state === s) == leave) begin
            errors++;
            $display("ERROR wait on state %0d ran out", s);
            summarize();
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic bring_up();
        int n;
        @(posedge sys_clk);
        rst <= 1'b1;
        flags <= '0;
        high_side_req <= 1'b0;
        low_side_req <= 1'b0;
        burst_mode <= 1'b0;
        hv_startup_enable <= 1'b1;
        supply_mv <= 500;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        settle(5);
        `CHK("charge_low", 1'b1, ctl.charge_low)
        @(posedge sys_clk);
        supply_mv <= 13000;
        flags.rail_good <= 1'b1;
        flags.input_sense_brown_in <= 1'b1;
        wait_st(LFS_PRGM, 10, 1'b0, n);
        `CHK("program_pins", 1'b1, ctl.program_pins)
        `CHK("pfc held off", 1'b0, pfc_on)
        @(posedge sys_clk);
        supply_mv <= 8800;
        settle(5);
        `CHK("charge_high", 1'b1, ctl.charge_high)
        settle(30);
        `CHK("held in prgm", LFS_PRGM, state)
        @(posedge sys_clk);
        supply_mv <= 16000;
        wait_st(LFS_RUN, 100, 1'b0, n);
        `CHK("charge off", 2'b00, {ctl.charge_low, ctl.charge_high})
        `CHK("pfc on", 1'b1, pfc_on)
    endtask

    task automatic vcc_case();
        int n;
        bit chg;
        bring_up();
        @(posedge sys_clk);
        high_side_req <= 1'b1;
        supply_mv <= 21000;
        wait_st(LFS_FAULT, 6, 1'b0, n);
        `CHK("vcc fault latency", 1'b1, n <= 4)
        `CHK("vcc cause", LFS_F_VCC, fault_cause)
        `CHK("gates off", 2'b00, {high_side_gate, low_side_gate})
        @(posedge sys_clk);
        high_side_req <= 1'b0;
        supply_mv <= 16000;
        wait_st(LFS_FAULT, IDLED + 20, 1'b1, n);
        `CHK("idle time", 1'b1, n >= IDLED - 4)
        chg = 1'b0;
        for (int i = 0; i < 100 && state !== LFS_RUN; i++) begin
            @(negedge sys_clk);
            chg = chg | ctl.charge_low | ctl.charge_high;
        end
        `CHK("restart run", LFS_RUN, state)
        `CHK("restart no charge", 1'b0, chg)
    endtask

    task automatic combined_protection_pin_case();
        int n;
        bring_up();
        @(posedge sys_clk);
        flags.prot_above_ovp <= 1'b1;
        repeat (OVPD - 10) @(posedge sys_clk);
        flags.prot_above_ovp <= 1'b0;
        settle(10);
        `CHK("short ovp", LFS_RUN, state)
        @(posedge sys_clk);
        flags.prot_above_ovp <= 1'b1;
        wait_st(LFS_FAULT, OVPD + 10, 1'b0, n);
        `CHK("ovp delay", 1'b1, n >= OVPD)
        `CHK("ovp cause", LFS_F_OVP, fault_cause)
        bring_up();
        @(posedge sys_clk);
        burst_mode <= 1'b1;
        flags.prot_below_otp <= 1'b1;
        settle(20);
        `CHK("otp in burst", LFS_RUN, state)
        @(posedge sys_clk);
        burst_mode <= 1'b0;
        wait_st(LFS_FAULT, 10, 1'b0, n);
        `CHK("otp cause", LFS_F_OTP, fault_cause)
        settle(IDLED + 10);
        `CHK("otp stays idle", LFS_FAULT, state)
        @(posedge sys_clk);
        flags.prot_below_otp <= 1'b0;
        wait_st(LFS_FAULT, 20, 1'b1, n);
        `CHK("otp restart", 1'b1, state !== LFS_FAULT)
    endtask

    task automatic gate_case();
        int n;
        bit ramp;
        bring_up();
        @(posedge sys_clk);
        flags.zcs_high <= 1'b1;
        high_side_req <= 1'b1;
        for (n = 0; n < 6 && high_side_gate !== 1'b1; n++) settle(1);
        settle(3);
        `CHK("zcs blanked", 1'b1, high_side_gate)
        ramp = 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            ramp = ramp | ctl.ramp_step_down;
        end
        `CHK("zcs cut", 1'b0, high_side_gate)
        `CHK("ramp step", 1'b1, ramp)
        @(posedge sys_clk);
        high_side_req <= 1'b0;
        flags.zcs_high <= 1'b0;
        flags.zcs_low <= 1'b1;
        settle(4);
        @(posedge sys_clk);
        high_side_req <= 1'b1;
        settle(14);
        `CHK("other zcs ignored", 1'b1, high_side_gate)
        @(posedge sys_clk);
        flags.zcs_high <= 1'b1;
        for (int i = 0; i < 60 && state !== LFS_FAULT; i++) begin
            @(posedge sys_clk);
            high_side_req <= i[0];
            settle(8);
        end
        `CHK("zcs cause", LFS_F_ZCS, fault_cause)
    endtask

    task automatic ocp_case();
        bring_up();
        @(posedge sys_clk);
        flags.ocp_pos <= 1'b1;
        for (int i = 1; i <= 8; i++) begin
            @(posedge sys_clk);
            high_side_req <= 1'b1;
            settle(8);
            if (i == 1) `CHK("ocp cut", 1'b0, high_side_gate)
            if (i == 7) `CHK("six ocp", LFS_RUN, state)
            @(posedge sys_clk);
            high_side_req <= 1'b0;
            settle(4);
        end
        `CHK("ocp cause", LFS_F_OCP, fault_cause)
    endtask

    task automatic olp_brown_case();
        int n;
        bring_up();
        @(posedge sys_clk);
        flags.ocp_neg <= 1'b1;
        low_side_req <= 1'b1;
        settle(8);
        `CHK("low ocp cut", 1'b0, low_side_gate)
        @(posedge sys_clk);
        low_side_req <= 1'b0;
        flags.ocp_neg <= 1'b0;
        flags.control_above_olp <= 1'b1;
        settle(5);
        `CHK("power limit", 1'b1, ctl.power_limit)
        wait_st(LFS_FAULT, OLPC + 20, 1'b0, n);
        `CHK("olp time", 1'b1, n >= OLPC - 4)
        `CHK("olp cause", LFS_F_OLP, fault_cause)
        bring_up();
        @(posedge sys_clk);
        flags.input_sense_brown_in <= 1'b0;
        wait_st(LFS_FAULT, 10, 1'b0, n);
        @(posedge sys_clk);
        flags.input_sense_brown_in <= 1'b1;
        wait_st(LFS_FAULT, IDLED, 1'b1, n);
        `CHK("brown in quick", 1'b1, n < 20)
        wait_st(LFS_RUN, 100, 1'b0, n);
        @(posedge sys_clk);
        supply_mv <= 8200;
        settle(8);
        `CHK("stop switching", LFS_FAULT, state)
        `CHK("retry pfc off", 1'b0, pfc_on)
    endtask

    initial begin
        vcc_case();
        combined_protection_pin_case();
        gate_case();
        ocp_case();
        olp_brown_case();
        summarize();
    end
endmodule
